// *** rt_ahb_slv.sv ***
// AHB-Lite slave front end, zero wait states, always OKAY
`timescale 1ns/1ps
`default_nettype none
`include "rt_map.svh"
module rt_ahb_slv (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus request
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	// Bus answer
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Core side
	rt_reg_if.slv regs
);
	logic take;
	logic wr_pend_reg;
	logic wr_pend_next;
	rt_pkg::rt_addr_t wr_addr_reg;
	rt_pkg::rt_addr_t wr_addr_next;
	rt_pkg::rt_word_t rdata_reg;
	rt_pkg::rt_word_t rdata_next;

	// Address phase accepted for whole-word transfers only
	assign take = hsel && htrans[`RT_HTRANS_NONSEQ_BIT] && hready && (hsize == `RT_HSIZE_WORD);
	assign regs.rd_addr = haddr[11:0];
	assign regs.wr_en = wr_pend_reg;
	assign regs.wr_addr = wr_addr_reg;
	assign regs.wr_data = hwdata;

	// Read data is fetched at the address phase so it stands in the data phase
	always_comb
	begin
		wr_pend_next = take && hwrite;
		wr_addr_next = take ? haddr[11:0] : wr_addr_reg;
		rdata_next = (take && !hwrite) ? regs.rd_data : rdata_reg;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 12'h000;
			rdata_reg <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			wr_pend_reg <= wr_pend_next;
			wr_addr_reg <= wr_addr_next;
			rdata_reg <= rdata_next;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	assign hrdata = rdata_reg;
endmodule : rt_ahb_slv
`default_nettype wire

// *** rt_chan.sv ***
// One system tick timer channel: capture or single-shot compare
`timescale 1ns/1ps
`default_nettype none
`include "rt_map.svh"
module rt_chan (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Time base
	input wire logic [33:0] now,
	// Configuration
	input wire logic res_sel,
	input wire logic cap_mode,
	// Software write of the compare value
	input wire logic wr_en,
	input wire logic [31:0] wr_data,
	// Capture trigger
	input wire logic cap_in,
	// Channel state
	output logic [31:0] value,
	output logic event_out
);
	logic [31:0] slice;
	logic [31:0] age;
	logic [31:0] value_reg;
	logic [31:0] value_next;
	logic armed_reg;
	logic armed_next;
	logic cap_prev_reg;
	logic cap_prev_next;
	logic event_reg;
	logic event_next;

	// 1 us slice is bits 33:2, 250 ns slice bits 31:0
	assign slice = res_sel ? now[33:2] : now[31:0];
	assign age = slice - value_reg;

	// Capture on a rising trigger, or fire once when the target is reached or lies just behind
	always_comb
	begin
		value_next = value_reg;
		armed_next = armed_reg;
		cap_prev_next = cap_in;
		event_next = 1'b0;
		if (wr_en)
		begin
			value_next = wr_data;
			armed_next = !cap_mode;
		end
		else if (cap_mode)
		begin
			if (cap_in && !cap_prev_reg)
			begin
				value_next = slice;
				event_next = 1'b1;
			end
		end
		else if (armed_reg && (age < `RT_PAST_WIN))
		begin
			event_next = 1'b1;
			armed_next = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			value_reg <= 32'h0000_0000;
			armed_reg <= 1'b0;
			cap_prev_reg <= 1'b0;
			event_reg <= 1'b0;
		end
		else
		begin
			value_reg <= value_next;
			armed_reg <= armed_next;
			cap_prev_reg <= cap_prev_next;
			event_reg <= event_next;
		end
	end

	assign value = value_reg;
	assign event_out = event_reg;
endmodule : rt_chan
`default_nettype wire

// *** rt_map.svh ***
// Register offsets, field positions, reset values and timing counts of the timebase block
`ifndef RT_MAP_SVH
`define RT_MAP_SVH

// Register byte offsets
`define RT_FINE_OFS 12'h000
`define RT_COARSE_OFS 12'h004
`define RT_INC_OFS 12'h008
`define RT_RTC_CMP_OFS 12'h00C
`define RT_RTC_CAP_OFS 12'h010
`define RT_STATUS_OFS 12'h014
`define RT_MASK_OFS 12'h018
`define RT_STIM_NOW_OFS 12'h01C
`define RT_STIM_RES_OFS 12'h020
`define RT_STIM_MODE_OFS 12'h024
`define RT_CTRL_OFS 12'h028
`define RT_CHAN_BASE_OFS 12'h040
`define RT_CHAN_LAST_OFS 12'h050

// Status and mask bit positions
`define RT_ST_RTC_CMP 0
`define RT_ST_RTC_CAP 1
`define RT_ST_CHAN0 2
`define RT_ST_WIDTH 7

// Control register bit positions
`define RT_CTRL_CAP_EN 0

// Reset values: one 32.768 kHz period, 30.517578125 us with 16 fraction bits
`define RT_INC_RESET 32'h001E_8480
`define RT_MASK_RESET 7'h00
`define RT_CTRL_RESET 1'b1

// Counter slices
`define RT_FINE_LSB 19
`define RT_COARSE_LSB 35
`define RT_STIM_LOAD_LSB 14

// Channel roles
`define RT_CHAN_COUNT 5
`define RT_CHAN_SYSTEM 0
`define RT_CHAN_RADIO_FIRST 1
`define RT_CHAN_RADIO_LAST 3
`define RT_CHAN_USER 4

// Timing: 250 ns system tick on a 5 ns bus clock
`define RT_CLK_NS 5
`define RT_TICK_NS 250
`define RT_TICK_CYC (`RT_TICK_NS / `RT_CLK_NS)

// Immediate past windows for compare qualification
`define RT_PAST_WIN 32'h0040_0000
`define RT_RTC_PAST_WIN 32'h8000_0000

// Bus encodings
`define RT_HTRANS_NONSEQ_BIT 1
`define RT_HSIZE_WORD 3'h2

`endif

// *** rt_pkg.sv ***
// Types shared by the timebase block modules
package rt_pkg;
	typedef logic [66:0] rt_acc_t;
	typedef logic [33:0] rt_tick_t;
	typedef logic [11:0] rt_addr_t;
	typedef logic [31:0] rt_word_t;
endpackage : rt_pkg

// *** rt_reg_if.sv ***
// Register access signals between the bus slave and the timebase core
`timescale 1ns/1ps
`default_nettype none
interface rt_reg_if;
	rt_pkg::rt_addr_t rd_addr;
	rt_pkg::rt_word_t rd_data;
	logic wr_en;
	rt_pkg::rt_addr_t wr_addr;
	rt_pkg::rt_word_t wr_data;
	modport slv (output rd_addr, output wr_en, output wr_addr, output wr_data, input rd_data);
	modport core (input rd_addr, input wr_en, input wr_addr, input wr_data, output rd_data);
endinterface : rt_reg_if
`default_nettype wire

// *** rt_top.sv ***
// Real-time counter and system tick timer with AHB-Lite registers
//
// Notes on behaviour
// - The real-time counter is a 67-bit accumulator with one compare and one capture channel, advanced by the low-frequency clock.
// - The real-time counter runs in active and standby and is cleared by reset or by the shutdown input.
// - Each rising edge of the low-frequency clock adds the programmed increment to the counter.
// - The increment is one low-frequency period in microseconds with 16 fraction bits.
// - A read-only fine view gives the counter with an 8 us least significant bit.
// - A read-only coarse view gives the counter with a 524 ms least significant bit.
// - The counter has one compare and one capture channel, and a compare match raises the standby wake request.
// - The system tick timer is reloaded from the real-time counter by hardware on every low-frequency edge; the code reloads on rising edges and in shutdown.
// - The system tick timer is a 34-bit wrapping counter with five channels.
// - Each channel picks a 32-bit slice at 1 us or at 250 ns resolution.
// - Each channel captures the time or fires a single-shot compare that stays quiet until rewritten.
// - Channel 0 serves system software, channels 1 to 3 the radio and channel 4 the user.
// - A compare value less than 2^22 ticks in the past fires at once.
// - The low-frequency clock is a nominal 32.768 kHz input from whatever source the system picks.
//
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "rt_map.svh"
module rt_top (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite request
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	// AHB-Lite answer
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Time base and power state
	input wire logic low_frequency_clock,
	input wire logic pwr_shutdown,
	// Capture triggers
	input wire logic rtc_capture_in,
	input wire logic [4:0] tick_capture_in,
	// Events and interrupt
	output logic [4:0] tick_event,
	output logic rtc_wake,
	output logic irq
);
	rt_reg_if regs ();

	// Low-frequency edge detect
	logic lf_prev_reg;
	logic lf_prev_next;
	logic lf_rise;

	// Real-time counter state
	rt_pkg::rt_acc_t acc_reg;
	rt_pkg::rt_acc_t acc_next;
	rt_pkg::rt_word_t inc_reg;
	rt_pkg::rt_word_t inc_next;
	rt_pkg::rt_word_t rtc_cmp_reg;
	rt_pkg::rt_word_t rtc_cmp_next;
	logic rtc_armed_reg;
	logic rtc_armed_next;
	rt_pkg::rt_word_t rtc_cap_reg;
	rt_pkg::rt_word_t rtc_cap_next;
	logic rtc_cap_prev_reg;
	logic rtc_cap_prev_next;
	logic ctrl_cap_en_reg;
	logic ctrl_cap_en_next;
	logic rtc_cmp_hit;
	logic rtc_cap_hit;
	rt_pkg::rt_word_t fine_view;
	rt_pkg::rt_word_t coarse_view;

	// System tick timer state
	rt_pkg::rt_tick_t stim_reg;
	rt_pkg::rt_tick_t stim_next;
	logic [5:0] presc_reg;
	logic [5:0] presc_next;
	logic [4:0] res_sel_reg;
	logic [4:0] res_sel_next;
	logic [4:0] cap_mode_reg;
	logic [4:0] cap_mode_next;
	logic [4:0] chan_wr;
	logic [4:0] chan_evt;
	rt_pkg::rt_word_t chan_val [0:4];

	// Status, mask and outputs
	logic [6:0] status_reg;
	logic [6:0] status_next;
	logic [6:0] mask_reg;
	logic [6:0] mask_next;
	logic [6:0] evt_set;
	logic [6:0] w1c;
	logic irq_next;
	logic wake_next;

	// Decoded register writes
	logic wr_inc;
	logic wr_rtc_cmp;
	logic wr_status;
	logic wr_mask;
	logic wr_res;
	logic wr_mode;
	logic wr_ctrl;

	rt_ahb_slv u_slv (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.regs(regs.slv)
	);

	// Write decode in the data phase
	assign wr_inc = regs.wr_en && (regs.wr_addr == `RT_INC_OFS);
	assign wr_rtc_cmp = regs.wr_en && (regs.wr_addr == `RT_RTC_CMP_OFS);
	assign wr_status = regs.wr_en && (regs.wr_addr == `RT_STATUS_OFS);
	assign wr_mask = regs.wr_en && (regs.wr_addr == `RT_MASK_OFS);
	assign wr_res = regs.wr_en && (regs.wr_addr == `RT_STIM_RES_OFS);
	assign wr_mode = regs.wr_en && (regs.wr_addr == `RT_STIM_MODE_OFS);
	assign wr_ctrl = regs.wr_en && (regs.wr_addr == `RT_CTRL_OFS);

	// The low-frequency clock is sampled as an ordinary input and its rising edge advances time
	assign lf_rise = low_frequency_clock && !lf_prev_reg;

	// Two read views of the accumulator
	assign fine_view = acc_reg[`RT_FINE_LSB +: 32];
	assign coarse_view = acc_reg[`RT_COARSE_LSB +: 32];

	// Compare fires when the fine view reaches or has just passed the target
	assign rtc_cmp_hit = rtc_armed_reg && ((fine_view - rtc_cmp_reg) < `RT_RTC_PAST_WIN);
	assign rtc_cap_hit = ctrl_cap_en_reg && rtc_capture_in && !rtc_cap_prev_reg;

	// Real-time counter next state
	always_comb
	begin
		lf_prev_next = low_frequency_clock;
		rtc_cap_prev_next = rtc_capture_in;
		acc_next = acc_reg;
		inc_next = wr_inc ? regs.wr_data : inc_reg;
		ctrl_cap_en_next = wr_ctrl ? regs.wr_data[`RT_CTRL_CAP_EN] : ctrl_cap_en_reg;
		rtc_cmp_next = rtc_cmp_reg;
		rtc_armed_next = rtc_armed_reg;
		rtc_cap_next = rtc_cap_reg;
		if (pwr_shutdown)
			acc_next = 67'h0;
		else if (lf_rise)
			acc_next = acc_reg + {35'h0, inc_reg};
		if (wr_rtc_cmp)
		begin
			rtc_cmp_next = regs.wr_data;
			rtc_armed_next = 1'b1;
		end
		else if (rtc_cmp_hit)
			rtc_armed_next = 1'b0;
		if (rtc_cap_hit)
			rtc_cap_next = fine_view;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			lf_prev_reg <= 1'b0;
			rtc_cap_prev_reg <= 1'b0;
			acc_reg <= 67'h0;
			inc_reg <= `RT_INC_RESET;
			ctrl_cap_en_reg <= `RT_CTRL_RESET;
			rtc_cmp_reg <= 32'h0000_0000;
			rtc_armed_reg <= 1'b0;
			rtc_cap_reg <= 32'h0000_0000;
		end
		else
		begin
			lf_prev_reg <= lf_prev_next;
			rtc_cap_prev_reg <= rtc_cap_prev_next;
			acc_reg <= acc_next;
			inc_reg <= inc_next;
			ctrl_cap_en_reg <= ctrl_cap_en_next;
			rtc_cmp_reg <= rtc_cmp_next;
			rtc_armed_reg <= rtc_armed_next;
			rtc_cap_reg <= rtc_cap_next;
		end
	end

	// System tick timer: 250 ns ticks, realigned to the real-time counter on each rising low-frequency edge and during shutdown
	always_comb
	begin
		stim_next = stim_reg;
		presc_next = presc_reg + 6'h01;
		res_sel_next = wr_res ? regs.wr_data[4:0] : res_sel_reg;
		cap_mode_next = wr_mode ? regs.wr_data[4:0] : cap_mode_reg;
		if (lf_rise || pwr_shutdown)
		begin
			stim_next = acc_next[`RT_STIM_LOAD_LSB +: 34];
			presc_next = 6'h00;
		end
		else if (presc_reg == 6'(`RT_TICK_CYC - 1))
		begin
			stim_next = stim_reg + 34'h1;
			presc_next = 6'h00;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			stim_reg <= 34'h0;
			presc_reg <= 6'h00;
			res_sel_reg <= 5'h00;
			cap_mode_reg <= 5'h00;
		end
		else
		begin
			stim_reg <= stim_next;
			presc_reg <= presc_next;
			res_sel_reg <= res_sel_next;
			cap_mode_reg <= cap_mode_next;
		end
	end

	// Five channels: 0 system, 1 to 3 radio, 4 user
	genvar gi;
	generate
		for (gi = 0; gi < `RT_CHAN_COUNT; gi = gi + 1)
		begin : g_chan
			assign chan_wr[gi] = regs.wr_en && (regs.wr_addr == (`RT_CHAN_BASE_OFS + 12'(gi * 4)));
			rt_chan u_chan (
				.clk(hclk),
				.rst_n(hresetn),
				.now(stim_reg),
				.res_sel(res_sel_reg[gi]),
				.cap_mode(cap_mode_reg[gi]),
				.wr_en(chan_wr[gi]),
				.wr_data(regs.wr_data),
				.cap_in(tick_capture_in[gi]),
				.value(chan_val[gi]),
				.event_out(chan_evt[gi])
			);
		end
	endgenerate

	// Sticky status, set wins over a write-one clear
	assign evt_set = {chan_evt, rtc_cap_hit, rtc_cmp_hit};
	assign w1c = wr_status ? regs.wr_data[6:0] : 7'h00;

	always_comb
	begin
		status_next = (status_reg & ~w1c) | evt_set;
		mask_next = wr_mask ? regs.wr_data[6:0] : mask_reg;
		irq_next = |(status_next & mask_next);
		wake_next = status_next[`RT_ST_RTC_CMP];
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			status_reg <= 7'h00;
			mask_reg <= `RT_MASK_RESET;
			irq <= 1'b0;
			rtc_wake <= 1'b0;
			tick_event <= 5'h00;
		end
		else
		begin
			status_reg <= status_next;
			mask_reg <= mask_next;
			irq <= irq_next;
			rtc_wake <= wake_next;
			tick_event <= chan_evt;
		end
	end

	// Read mux, unmapped offsets read zero
	always_comb
	begin
		regs.rd_data = 32'h0000_0000;
		case (regs.rd_addr)
			`RT_FINE_OFS: regs.rd_data = fine_view;
			`RT_COARSE_OFS: regs.rd_data = coarse_view;
			`RT_INC_OFS: regs.rd_data = inc_reg;
			`RT_RTC_CMP_OFS: regs.rd_data = rtc_cmp_reg;
			`RT_RTC_CAP_OFS: regs.rd_data = rtc_cap_reg;
			`RT_STATUS_OFS: regs.rd_data = {25'h0, status_reg};
			`RT_MASK_OFS: regs.rd_data = {25'h0, mask_reg};
			`RT_STIM_NOW_OFS: regs.rd_data = stim_reg[31:0];
			`RT_STIM_RES_OFS: regs.rd_data = {27'h0, res_sel_reg};
			`RT_STIM_MODE_OFS: regs.rd_data = {27'h0, cap_mode_reg};
			`RT_CTRL_OFS: regs.rd_data = {31'h0, ctrl_cap_en_reg};
			default:
			begin
				if ((regs.rd_addr >= `RT_CHAN_BASE_OFS) && (regs.rd_addr <= `RT_CHAN_LAST_OFS)
					&& (regs.rd_addr[1:0] == 2'h0))
					regs.rd_data = chan_val[regs.rd_addr[4:2]];
			end
		endcase
	end
endmodule : rt_top
`default_nettype wire

// *** rt_top_props.sv ***
// Port checker of the timebase block: bus answers, events, wake and interrupt
`timescale 1ns/1ps
`default_nettype none
module rt_top_props (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Power state and events
	input wire logic pwr_shutdown,
	input wire logic [4:0] tick_event,
	input wire logic rtc_wake,
	input wire logic irq
);
	// Accepted word address phase
	logic req;
	assign req = hsel && htrans[1] && hready && hsize == 3'h2;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Read of an unmapped hole
	sequence s_rd_gap;
		req && !hwrite && ((haddr[11:0] > 12'h028 && haddr[11:0] < 12'h040) || haddr[11:0] > 12'h050);
	endsequence
	// Read of a time view while shutdown has held the counters clear
	sequence s_rd_off;
		req && !hwrite && pwr_shutdown && $past(pwr_shutdown) && (haddr[11:0] == 12'h000 || haddr[11:0] == 12'h01C);
	endsequence
	property p_bus_okay; hreadyout && !hresp; endproperty
	property p_rd_gap; s_rd_gap |=> hrdata == 32'h0000_0000; endproperty
	property p_rd_off; s_rd_off |=> hrdata == 32'h0000_0000; endproperty
	property p_rd_hold; !$past(req && !hwrite) |-> $stable(hrdata); endproperty
	property p_ev_pulse; tick_event != 5'h00 |=> (tick_event & $past(tick_event)) == 5'h00; endproperty
	// A write lands at the edge ending its data phase, so its address phase lies two samples back
	property p_wake_fell; $fell(rtc_wake) |-> $past(req && hwrite, 2); endproperty
	property p_irq_fell; $fell(irq) |-> $past(req && hwrite, 2); endproperty
	property p_reset_quiet; $rose(hresetn) |-> !irq && !rtc_wake && tick_event == 5'h00; endproperty
	a_bus_okay: assert property (p_bus_okay) else $error("bus answer not ready or not okay");
	a_rd_gap: assert property (p_rd_gap) else $error("unmapped read not zero");
	a_rd_off: assert property (p_rd_off) else $error("time view not clear in shutdown");
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
	a_ev_pulse: assert property (p_ev_pulse) else $error("channel event longer than one cycle");
	a_wake_fell: assert property (p_wake_fell) else $error("wake dropped without a write");
	a_irq_fell: assert property (p_irq_fell) else $error("interrupt dropped without a write");
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
endmodule : rt_top_props
bind rt_top rt_top_props u_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hrdata,
	.hreadyout, .hresp, .pwr_shutdown, .tick_event, .rtc_wake, .irq);
`default_nettype wire

// *** rt_top_tb.sv ***
// Self-checking bench of the timebase block driven over its register bus
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module rt_top_tb;
	// Design ports
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic low_frequency_clock, pwr_shutdown, rtc_capture_in, rtc_wake, irq;
	logic [4:0] tick_capture_in, tick_event;
	// Bench state
	int err_count = 0;
	int checks_done = 0;
	int cyc = 0;
	int ev_cnt [5] = '{default: 0};
	logic [66:0] acc;
	rt_pkg::rt_word_t inc_val, rd, t;
	logic [11:0] rst_addr [14] = '{12'h008, 12'h018, 12'h028, 12'h014, 12'h000, 12'h004, 12'h010, 12'h020,
		12'h024, 12'h040, 12'h044, 12'h048, 12'h04C, 12'h050};
	assign hready = hreadyout;
	rt_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout,
		.hresp, .low_frequency_clock, .pwr_shutdown, .rtc_capture_in, .tick_capture_in, .tick_event, .rtc_wake, .irq);
	// Clock
	initial
	begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	// Event counts per channel and hang guard
	always @(posedge hclk)
	begin
		for (int i = 0; i < 5; i++) ev_cnt[i] <= ev_cnt[i] + int'(tick_event[i]);
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			err_count++;
			summarize();
		end
	end
	// One single word transfer: address phase, then data phase
	task automatic xfer(input logic w, input logic [11:0] a, input rt_pkg::rt_word_t wd, output rt_pkg::rt_word_t r);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : xfer
	task automatic wr(input logic [11:0] a, input rt_pkg::rt_word_t d);
		rt_pkg::rt_word_t x;
		xfer(1'b1, a, d, x);
	endtask : wr
	task automatic rdc(input logic [11:0] a, input rt_pkg::rt_word_t e);
		xfer(1'b0, a, 32'h0, rd);
		`CHK(rd, e)
	endtask : rdc
	// One low-frequency period and the expected accumulation
	task automatic lf_tick();
		low_frequency_clock <= 1'b0;
		repeat (2) @(posedge hclk);
		low_frequency_clock <= 1'b1;
		repeat (2) @(posedge hclk);
		acc = acc + {35'h0, inc_val};
	endtask : lf_tick
	task automatic wait_ev(input int i);
		for (int n = 0; n < 500 && ev_cnt[i] == 0; n++) @(posedge hclk);
	endtask : wait_ev
	task automatic summarize();
		if (err_count == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : summarize
	// Main sequence
	initial
	begin
		hresetn = 1'b0;
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		{low_frequency_clock, pwr_shutdown, rtc_capture_in, tick_capture_in} = '0;
		acc = '0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		foreach (rst_addr[i]) rdc(rst_addr[i], i == 0 ? 32'h001E_8480 : i == 2 ? 32'h0000_0001 : 32'h0);
		wr(12'h000, 32'hFFFF_FFFF);
		rdc(12'h000, 32'h0);
		wr(12'h030, 32'h1234_5678);
		rdc(12'h030, 32'h0);
		// Large increment so the coarse view moves too
		inc_val = 32'hFFFF_FFFF;
		wr(12'h008, inc_val);
		repeat (40) lf_tick();
		rdc(12'h000, acc[50:19]);
		rdc(12'h004, acc[66:35]);
		rdc(12'h008, inc_val);
		rdc(12'h01C, acc[45:14]);
		// Capture of the fine view
		rtc_capture_in <= 1'b1;
		repeat (2) @(posedge hclk);
		rtc_capture_in <= 1'b0;
		repeat (3) @(posedge hclk);
		rdc(12'h010, acc[50:19]);
		rdc(12'h014, 32'h0000_0002);
		wr(12'h014, 32'h0000_0002);
		// Shutdown clears both counters and swallows a tick
		pwr_shutdown <= 1'b1;
		lf_tick();
		rdc(12'h000, 32'h0);
		rdc(12'h01C, 32'h0);
		pwr_shutdown <= 1'b0;
		acc = '0;
		rdc(12'h004, 32'h0);
		rdc(12'h014, 32'h0);
		// Channel 3 at 1 us, channel 4 captures, others compare at 250 ns
		wr(12'h020, 32'h0000_0008);
		wr(12'h024, 32'h0000_0010);
		rdc(12'h020, 32'h0000_0008);
		xfer(1'b0, 12'h01C, 32'h0, t);
		wr(12'h040, t + 32'h3);
		// Leave room for an early fire to reach the event counter before looking
		repeat (4) @(posedge hclk);
		`CHK(ev_cnt[0], 0)
		wr(12'h044, t - 32'h0000_1000);
		wr(12'h048, t - 32'h0050_0000);
		wr(12'h04C, (t >> 2) - 32'h1);
		wait_ev(0);
		repeat (400) @(posedge hclk);
		`CHK(ev_cnt[0], 1)
		`CHK(ev_cnt[1], 1)
		`CHK(ev_cnt[2], 0)
		`CHK(ev_cnt[3], 1)
		xfer(1'b0, 12'h01C, 32'h0, t);
		tick_capture_in <= 5'h10;
		repeat (2) @(posedge hclk);
		tick_capture_in <= 5'h00;
		wait_ev(4);
		xfer(1'b0, 12'h050, 32'h0, rd);
		`CHK(rd - t < 32'h2, 1'b1)
		`CHK(ev_cnt[4], 1)
		// Status, mask and interrupt
		rdc(12'h014, 32'h0000_006C);
		`CHK(irq, 1'b0)
		wr(12'h018, 32'h0000_0004);
		repeat (2) @(posedge hclk);
		`CHK(irq, 1'b1)
		wr(12'h014, 32'h0000_0004);
		repeat (2) @(posedge hclk);
		`CHK(irq, 1'b0)
		rdc(12'h014, 32'h0000_0068);
		wr(12'h014, 32'h0000_0068);
		// Compare ahead of the fine view holds off, at the fine view wakes
		wr(12'h018, 32'h0000_0001);
		wr(12'h00C, 32'h0000_0001);
		repeat (4) @(posedge hclk);
		`CHK(rtc_wake, 1'b0)
		wr(12'h00C, 32'h0);
		repeat (3) @(posedge hclk);
		`CHK(rtc_wake, 1'b1)
		`CHK(irq, 1'b1)
		wr(12'h014, 32'h0000_0001);
		repeat (2) @(posedge hclk);
		`CHK(rtc_wake, 1'b0)
		`CHK(irq, 1'b0)
		summarize();
	end
endmodule : rt_top_tb
`default_nettype wire
